// >>> pkg/plp_defines.vh
// constants for the programming link physical layer
// Function
// - release disables link unless access enable set
// - frame: start, eight data, parity, two stops
// - data bits go least significant first
// - start bit low, both stop bits high
// - parity is xor of eight data bits
// - break/idle: twelve or more low/high bits
// - change on falling, sample on rising edges
// - default to receive mode awaiting start
// - receive shifts through second stop, presents byte
// - stop bit read zero gives frame error
// - parity mismatch at frame end gives error
// - all zero frame gives break exception
// - transmit loads byte, shifts one frame out
// - drive zeros; ones driven first cycle only
// - low while tristated is collision, stop driving
// - exception enters error state until break
// - guard time plus two idle before the first start after receive
// - guard field defaults to 128 bits
// - error state aborts work until break received
`ifndef PLP_DEFINES_VH
`define PLP_DEFINES_VH
// register byte addresses
`define PLP_A_CTRL      5'h00
`define PLP_A_PCR       5'h04
`define PLP_A_STAT      5'h08
`define PLP_A_RXD       5'h0c
`define PLP_A_TXD       5'h10
// control bits
`define PLP_C_TXMODE    0
`define PLP_C_MEMEN     1
// status bits
`define PLP_S_ACTIVE    0
`define PLP_S_TXBUSY    1
`define PLP_S_ERRST     2
`define PLP_S_RXVALID   3
`define PLP_S_FRAME     4
`define PLP_S_PARITY    5
`define PLP_S_BREAK     6
`define PLP_S_COLL      7
// values and counts
`define PLP_GUARD_RST   8'h80
`define PLP_EN_HIGHS    5'h10
`define PLP_RX_LAST     4'ha
`define PLP_TX_BITS     4'hc
`define PLP_TURN_IDLE   9'h002
`define PLP_RESP_OK     2'h0
`define PLP_RESP_ERR    2'h2
`endif

// >>> verilog/plp_sync.v
// two flip-flop synchroniser for pin inputs
module plp_sync #(
	parameter W = 1
) (
	// clock and reset
	input  wire         mclk,
	input  wire         rst,
	// async in, synced out
	input  wire [W-1:0] async_in,
	output reg  [W-1:0] sync_out
);
	reg [W-1:0] meta_q;

	always @(posedge mclk) begin
		if (rst) begin
			meta_q   <= {W{1'b1}};
			sync_out <= {W{1'b1}};
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // plp_sync

// >>> verilog/plp_top.v
// programming link physical layer with axi4-lite registers
`include "plp_defines.vh"
module plp_top (
	// clock and reset
	input  wire        mclk,
	input  wire        rst,
	// link pins
	input  wire        link_enable_pin,
	input  wire        prog_clock,
	input  wire        prog_data_line_in,
	output reg         prog_data_line_out,
	output reg         prog_data_line_oe,
	// axi4-lite write address
	input  wire [4:0]  s_axi_awaddr,
	input  wire        s_axi_awvalid,
	output reg         s_axi_awready,
	// axi4-lite write data
	input  wire [31:0] s_axi_wdata,
	input  wire [3:0]  s_axi_wstrb,
	input  wire        s_axi_wvalid,
	output reg         s_axi_wready,
	// axi4-lite write response
	output reg  [1:0]  s_axi_bresp,
	output reg         s_axi_bvalid,
	input  wire        s_axi_bready,
	// axi4-lite read address
	input  wire [4:0]  s_axi_araddr,
	input  wire        s_axi_arvalid,
	output reg         s_axi_arready,
	// axi4-lite read data
	output reg  [31:0] s_axi_rdata,
	output reg  [1:0]  s_axi_rresp,
	output reg         s_axi_rvalid,
	input  wire        s_axi_rready
);
	////////////////////////////////////////////////////////////////
	// pin synchronisers and clock edge detection
	wire [2:0] pins_s;
	reg        clk_d_q;
	plp_sync #(
		.W (3)
	) u_sync (
		.mclk     (mclk),
		.rst      (rst),
		.async_in ({link_enable_pin, prog_clock, prog_data_line_in}),
		.sync_out (pins_s)
	);
	wire en_pin = pins_s[2];
	wire din    = pins_s[0];
	always @(posedge mclk) begin
		if (rst)
			clk_d_q <= 1'b1;
		else
			clk_d_q <= pins_s[1];
	end

	wire rise = pins_s[1] & ~clk_d_q;
	wire fall = ~pins_s[1] & clk_d_q;
	////////////////////////////////////////////////////////////////
	// registers and state
	reg        txmode_q;
	reg        memen_q;
	reg [7:0]  guard_q;
	reg [7:0]  rxd_q;
	reg [7:0]  txd_q;
	reg        tx_pend_q;
	reg        rxv_q;
	reg        f_frame_q;
	reg        f_par_q;
	reg        f_brk_q;
	reg        f_coll_q;
	reg        err_q;
	reg        active_q;
	reg [4:0]  highs_q;
	// receiver
	reg        rx_act_q;
	reg [3:0]  rx_cnt_q;
	reg [10:0] rx_sh_q;
	reg        rx_par_q;
	reg        brk_wait_q;
	// transmitter
	reg [1:0]  tx_st_q;
	reg [8:0]  gcnt_q;
	reg [11:0] tx_sh_q;
	reg [3:0]  tx_idx_q;
	reg        lastb_q;
	reg        turn_q;
	localparam TX_IDLE  = 2'b00;
	localparam TX_GUARD = 2'b01;
	localparam TX_FRAME = 2'b10;
	// axi holding registers
	reg        aw_h_q;
	reg        w_h_q;
	reg [4:0]  awa_q;
	reg [31:0] wd_q;
	reg [3:0]  ws_q;
	wire do_wr  = aw_h_q & w_h_q & ~s_axi_bvalid;
	wire wr_st  = do_wr & (awa_q == `PLP_A_STAT) & ws_q[0];
	wire rd_go  = s_axi_arvalid & s_axi_arready;
	wire rd_rxd = rd_go & (s_axi_araddr == `PLP_A_RXD);
	// receiver events for this rising edge
	wire [10:0] rx_nv   = {din, rx_sh_q[10:1]};
	wire        rx_end  = active_q & ~txmode_q & rise & rx_act_q
	                      & (rx_cnt_q == `PLP_RX_LAST);
	wire        ev_brk  = rx_end & (rx_nv == 11'h000);
	wire        ev_fr   = rx_end & ~ev_brk & ~(rx_nv[9] & rx_nv[10]);
	wire        ev_par  = rx_end & ~ev_brk & (rx_par_q != rx_nv[8]);
	wire        ev_ok   = rx_end & ~ev_brk & ~ev_fr & ~ev_par;
	wire        ev_coll = active_q & rise & (tx_st_q == TX_FRAME)
	                      & ~prog_data_line_oe & ~din;
	wire        ev_exc  = ev_fr | ev_par | ev_coll;
	////////////////////////////////////////////////////////////////
	// session enable and disable
	always @(posedge mclk) begin
		if (rst) begin
			active_q <= 1'b0;
			highs_q  <= 5'h00;
		end else if (!active_q) begin
			if (!en_pin || (rise && !din))
				highs_q <= 5'h00;
			else if (rise)
				highs_q <= highs_q + 5'h01;
			if (en_pin && highs_q == `PLP_EN_HIGHS)
				active_q <= 1'b1;
		end else begin
			highs_q <= 5'h00;
			if (!en_pin && !memen_q)
				active_q <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////
	// receiver
	always @(posedge mclk) begin
		if (rst || !active_q || txmode_q) begin
			rx_act_q   <= 1'b0;
			rx_cnt_q   <= 4'h0;
			rx_sh_q    <= 11'h7ff;
			rx_par_q   <= 1'b0;
			brk_wait_q <= brk_wait_q & ~rst & active_q;
		end else if (rise) begin
			if (!rx_act_q) begin
				// start on low, high is idle
				if (!din && !brk_wait_q) begin
					rx_act_q <= 1'b1;
					rx_cnt_q <= 4'h0;
					rx_par_q <= 1'b0;
				end
				if (din)
					brk_wait_q <= 1'b0;
			end else begin
				// first bit lands in bit zero
				rx_sh_q <= rx_nv;
				rx_cnt_q <= rx_cnt_q + 4'h1;
				if (rx_cnt_q < 4'h8)
					rx_par_q <= rx_par_q ^ din;
				if (rx_end) begin
					rx_act_q <= 1'b0;
					// a long break must not restart a frame
					// wait out the low level
					brk_wait_q <= ev_brk;
				end
			end
		end
	end
	////////////////////////////////////////////////////////////////
	// exception flags, error state and received byte
	always @(posedge mclk) begin
		if (rst) begin
			err_q     <= 1'b0;
			rxd_q     <= 8'h00;
			rxv_q     <= 1'b0;
			f_frame_q <= 1'b0;
			f_par_q   <= 1'b0;
			f_brk_q   <= 1'b0;
			f_coll_q  <= 1'b0;
		end else begin
			if (ev_exc)
				err_q <= 1'b1;
			else if (ev_brk)
				err_q <= 1'b0;
			if (ev_ok && !err_q) begin
				rxd_q <= rx_nv[7:0];
				rxv_q <= 1'b1;
			end else if (rd_rxd) begin
				rxv_q <= 1'b0;
			end
			// sticky flags, write one clears, set wins
			f_frame_q <= ev_fr | (f_frame_q & ~(wr_st & wd_q[`PLP_S_FRAME]));
			f_par_q   <= ev_par | (f_par_q & ~(wr_st & wd_q[`PLP_S_PARITY]));
			f_brk_q   <= ev_brk | (f_brk_q & ~(wr_st & wd_q[`PLP_S_BREAK]));
			f_coll_q  <= ev_coll | (f_coll_q & ~(wr_st & wd_q[`PLP_S_COLL]));
		end
	end
	////////////////////////////////////////////////////////////////
	// transmitter
	wire tx_go = active_q & txmode_q & tx_pend_q & ~err_q & (tx_st_q == TX_IDLE);
	always @(posedge mclk) begin
		if (rst || !active_q || ev_coll) begin
			tx_st_q            <= TX_IDLE;
			prog_data_line_oe  <= 1'b0;
			prog_data_line_out <= 1'b1;
			lastb_q            <= 1'b1;
			tx_idx_q           <= 4'h0;
			gcnt_q             <= 9'h000;
			tx_sh_q            <= 12'hfff;
		end else begin
			case (tx_st_q)
			TX_IDLE: begin
				if (tx_go) begin
					tx_sh_q  <= {2'b11, ^txd_q, txd_q, 1'b0};
					tx_idx_q <= 4'h0;
					tx_st_q  <= TX_GUARD;
					// guard plus two idle on turnaround
					gcnt_q   <= turn_q ? ({1'b0, guard_q} + `PLP_TURN_IDLE) : 9'h000;
				end
			end
			TX_GUARD: begin
				// leave as soon as the idle falls are spent, so the start bit rides the next fall
				if (gcnt_q == 9'h000)
					tx_st_q <= TX_FRAME;
				else if (fall)
					gcnt_q <= gcnt_q - 9'h001;
			end
			TX_FRAME: begin
				if (fall) begin
					if (tx_idx_q == `PLP_TX_BITS) begin
						prog_data_line_oe  <= 1'b0;
						prog_data_line_out <= 1'b1;
						lastb_q            <= 1'b1;
						tx_st_q            <= TX_IDLE;
					end else begin
						prog_data_line_out <= tx_sh_q[0];
						prog_data_line_oe  <= ~tx_sh_q[0] | ~lastb_q;
						lastb_q            <= tx_sh_q[0];
						tx_sh_q  <= {1'b1, tx_sh_q[11:1]};
						tx_idx_q <= tx_idx_q + 4'h1;
					end
				end
			end
			default: tx_st_q <= TX_IDLE;
			endcase
		end
	end
	// the first frame after receive owes the guard time
	always @(posedge mclk) begin
		if (rst || !txmode_q)
			turn_q <= 1'b1;
		else if (tx_go)
			turn_q <= 1'b0;
	end
	////////////////////////////////////////////////////////////////
	// axi4-lite write channel
	always @(posedge mclk) begin
		if (rst) begin
			aw_h_q        <= 1'b0;
			w_h_q         <= 1'b0;
			awa_q         <= 5'h00;
			wd_q          <= 32'h0000_0000;
			ws_q          <= 4'h0;
			s_axi_awready <= 1'b0;
			s_axi_wready  <= 1'b0;
			s_axi_bvalid  <= 1'b0;
			s_axi_bresp   <= `PLP_RESP_OK;
		end else begin
			s_axi_awready <= ~aw_h_q & ~(s_axi_awvalid & s_axi_awready);
			s_axi_wready  <= ~w_h_q & ~(s_axi_wvalid & s_axi_wready);
			if (s_axi_awvalid && s_axi_awready) begin
				aw_h_q <= 1'b1;
				awa_q  <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_h_q <= 1'b1;
				wd_q  <= s_axi_wdata;
				ws_q  <= s_axi_wstrb;
			end
			if (do_wr) begin
				aw_h_q       <= 1'b0;
				w_h_q        <= 1'b0;
				s_axi_bvalid <= 1'b1;
				case (awa_q)
				`PLP_A_CTRL, `PLP_A_PCR, `PLP_A_STAT, `PLP_A_TXD:
					s_axi_bresp <= `PLP_RESP_OK;
				default:
					s_axi_bresp <= `PLP_RESP_ERR;
				endcase
			end else if (s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end
	// software writable fields
	always @(posedge mclk) begin
		if (rst) begin
			txmode_q  <= 1'b0;
			memen_q   <= 1'b0;
			guard_q   <= `PLP_GUARD_RST;
			txd_q     <= 8'h00;
			tx_pend_q <= 1'b0;
		end else begin
			if (do_wr && ws_q[0] && awa_q == `PLP_A_CTRL) begin
				txmode_q <= wd_q[`PLP_C_TXMODE];
				memen_q  <= wd_q[`PLP_C_MEMEN];
			end
			if (do_wr && ws_q[0] && awa_q == `PLP_A_PCR)
				guard_q <= wd_q[7:0];
			if (do_wr && ws_q[0] && awa_q == `PLP_A_TXD) begin
				txd_q     <= wd_q[7:0];
				tx_pend_q <= 1'b1;
			end else if (tx_go || !txmode_q) begin
				tx_pend_q <= 1'b0;
			end
			if (ev_exc || err_q || !active_q)
				txmode_q <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////////
	// axi4-lite read channel
	wire [7:0] stat = {f_coll_q, f_brk_q, f_par_q, f_frame_q, rxv_q, err_q,
	                   (tx_st_q != TX_IDLE) | tx_pend_q, active_q};
	always @(posedge mclk) begin
		if (rst) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= `PLP_RESP_OK;
		end else begin
			s_axi_arready <= ~s_axi_rvalid & ~rd_go;
			if (rd_go) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= `PLP_RESP_OK;
				case (s_axi_araddr)
				`PLP_A_CTRL: s_axi_rdata <= {30'h0, memen_q, txmode_q};
				`PLP_A_PCR:  s_axi_rdata <= {24'h0, guard_q};
				`PLP_A_STAT: s_axi_rdata <= {24'h0, stat};
				`PLP_A_RXD:  s_axi_rdata <= {24'h0, rxd_q};
				`PLP_A_TXD:  s_axi_rdata <= {24'h0, txd_q};
				default: begin
					s_axi_rdata <= 32'h0000_0000;
					s_axi_rresp <= `PLP_RESP_ERR;
				end
				endcase
			end else if (s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end
endmodule // plp_top

// >>> testbench/plp_asserts.sv
// port checker for the programming link physical layer
module plp_asserts (
	// clock, reset and link pins
	input wire logic       mclk,
	input wire logic       rst,
	input wire logic       prog_clock,
	input wire logic       prog_data_line_out,
	input wire logic       prog_data_line_oe,
	// register bus handshakes
	input wire logic       s_axi_awvalid,
	input wire logic       s_axi_awready,
	input wire logic       s_axi_wvalid,
	input wire logic       s_axi_wready,
	input wire logic       s_axi_bvalid,
	input wire logic       s_axi_bready,
	input wire logic       s_axi_arvalid,
	input wire logic       s_axi_arready,
	input wire logic [1:0] s_axi_rresp,
	input wire logic       s_axi_rvalid,
	input wire logic       s_axi_rready
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge mclk); endclocking
	default disable iff (rst);
	sequence s_wtake;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_wdone;
		##[1:3] s_axi_bvalid;
	endsequence
	property p_zero_drv; !prog_data_line_out |-> prog_data_line_oe; endproperty
	a_zero_drv: assert property (p_zero_drv) else $error("low level not driven");
	// raw clock still low some cycles after its fall, so drive changes must see it low
	property p_fall_only;
		($rose(prog_data_line_oe) || $changed(prog_data_line_out)) |-> !prog_clock;
	endproperty
	a_fall_only: assert property (p_fall_only) else $error("line changed off fall");
	property p_rst_quiet;
		disable iff (1'b0) rst |=> !prog_data_line_oe && !s_axi_bvalid && !s_axi_rvalid;
	endproperty
	a_rst_quiet: assert property (p_rst_quiet) else $error("not quiet after reset");
	property p_wresp; s_wtake |-> s_wdone; endproperty
	a_wresp: assert property (p_wresp) else $error("write response late");
	property p_bhold; s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid; endproperty
	a_bhold: assert property (p_bhold) else $error("bvalid dropped early");
	property p_rhold;
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rresp);
	endproperty
	a_rhold: assert property (p_rhold) else $error("read answer not held");
	property p_rresp; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid; endproperty
	a_rresp: assert property (p_rresp) else $error("read answer late");
	property p_wbusy; s_axi_bvalid |-> !s_axi_awready && !s_axi_wready; endproperty
	a_wbusy: assert property (p_wbusy) else $error("write taken while answering");
endmodule // plp_asserts

bind plp_top plp_asserts plp_asserts_inst (.mclk(mclk), .rst(rst), .prog_clock(prog_clock),
	.prog_data_line_out(prog_data_line_out), .prog_data_line_oe(prog_data_line_oe),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
	.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
	.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
	.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// >>> testbench/plp_prog_model.sv
// behavioural model of the external programmer
module plp_prog_model (
	// device side of the data pin
	input wire logic dev_oe,
	input wire logic dev_out,
	// programmer pins
	output logic     prog_clock,
	output logic     line
);
	timeunit 1ns;
	timeprecision 1ps;
	logic        ext_oe;
	logic        ext_val;
	logic [31:0] cap;
	// pull-up holds the line unless someone pulls it low
	assign line = ((dev_oe && !dev_out) || (ext_oe && !ext_val)) ? 1'b0 : 1'b1;
	initial begin
		prog_clock = 1'b1;
		ext_oe = 1'b0;
		ext_val = 1'b1;
		cap = '0;
	end
	// change on fall, sample on rise
	task automatic bits(input int n, input logic [31:0] v, input logic drv);
		#3;
		for (int i = 0; i < n; i++) begin
			#80 prog_clock = 1'b0;
			ext_oe = drv;
			ext_val = v[i];
			#80 prog_clock = 1'b1;
			cap = {line, cap[31:1]};
		end
		// hold the last level: letting go here would move the line on a sampling edge
	endtask
endmodule // plp_prog_model

// >>> testbench/plp_top_tb.sv
// self-checking bench for the programming link physical layer
`include "plp_defines.vh"
module plp_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic        mclk, rst, en_pin, pclk, line, oe, dout;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [4:0]  awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	int          bad_count, checks;
	plp_top plp_top_inst (.mclk(mclk), .rst(rst), .link_enable_pin(en_pin),
		.prog_clock(pclk), .prog_data_line_in(line), .prog_data_line_out(dout),
		.prog_data_line_oe(oe), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
		.s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
		.s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
		.s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
		.s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
	plp_prog_model plp_prog_model_inst (.dev_oe(oe), .dev_out(dout), .prog_clock(pclk),
		.line(line));
	initial begin
		mclk = 1'b0;
		forever #5 mclk = ~mclk;
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic end_sim(input bit to);
		if (to)
			bad_count++;
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask
	task automatic chk(input logic [31:0] s, input logic [31:0] e, input string w);
		checks++;
		if (s !== e) begin
			bad_count++;
			$display("unexpected %s expected %h seen %h", w, e, s);
		end
	endtask
	task automatic wr(input logic [4:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge mclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge mclk);
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			n++;
		end while (!bvalid && n < 99);
		bready <= 1'b0;
		chk(bresp, 32'h0, "bresp");
		if (n >= 99) end_sim(1);
	endtask
	task automatic rd(input logic [4:0] a, input logic [31:0] m, input logic [31:0] e,
		input logic [1:0] r = 2'h0);
		int n;
		n = 0;
		@(posedge mclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge mclk);
			if (arready) arvalid <= 1'b0;
			n++;
		end while (!rvalid && n < 99);
		rready <= 1'b0;
		chk(rdata & m, e, "rdata");
		chk(rresp, r, "rresp");
		if (n >= 99) end_sim(1);
	endtask
	function automatic logic [11:0] fr(input logic [7:0] b);
		return {2'b11, ^b, b, 1'b0};
	endfunction
	task automatic clk_bits(input int n, input logic [31:0] v, input logic drv);
		plp_prog_model_inst.bits(n, v, drv);
	endtask
	// two idle bits before each frame
	task automatic send(input logic [11:0] f);
		clk_bits(14, {18'h0, f, 2'b11}, 1'b1);
		repeat (8) @(posedge mclk);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		rst = 1'b1;
		en_pin = 1'b0;
		awvalid = 1'b0;
		wvalid = 1'b0;
		bready = 1'b0;
		arvalid = 1'b0;
		rready = 1'b0;
		awaddr = '0;
		araddr = '0;
		wdata = '0;
		wstrb = 4'hf;
		bad_count = 0;
		checks = 0;
		repeat (4) @(posedge mclk);
		rst <= 1'b0;
		repeat (2) @(posedge mclk);
		rd(`PLP_A_PCR, 32'hff, 32'h80);
		rd(`PLP_A_STAT, 32'hff, 32'h00);
		rd(5'h14, 32'hffffffff, 32'h0, 2'h2);
		$display("reset values done");
		// enable held until the disable test, sixteen high clocks
		en_pin <= 1'b1;
		repeat (4) @(posedge mclk);
		clk_bits(16, 32'hffff, 1'b1);
		// the last rise needs a few clocks through the synchroniser
		repeat (8) @(posedge mclk);
		rd(`PLP_A_STAT, 32'h07, 32'h01);
		send(fr(8'ha5));
		rd(`PLP_A_STAT, 32'hfc, 32'h08);
		rd(`PLP_A_RXD, 32'hff, 32'ha5);
		$display("receive done");
		for (int i = 0; i < 2; i++) begin
			send(i ? fr(8'h66) & 12'hbff : fr(8'h3c) ^ 12'h200);
			rd(`PLP_A_STAT, 32'h34, i ? 32'h14 : 32'h24);
			send(fr(8'h11));
			rd(`PLP_A_STAT, 32'h08, 32'h00);
			send(12'h000);
			rd(`PLP_A_STAT, 32'h44, 32'h40);
			wr(`PLP_A_STAT, 32'hf0);
			rd(`PLP_A_STAT, 32'hf4, 32'h00);
		end
		$display("receive faults done");
		wr(`PLP_A_PCR, 32'h02);
		wr(`PLP_A_CTRL, 32'h01);
		wr(`PLP_A_TXD, 32'h5a);
		clk_bits(16, 32'h0, 1'b0);
		chk(plp_prog_model_inst.cap[31:16], {fr(8'h5a), 4'hf}, "tx line");
		clk_bits(1, 32'h0, 1'b0);
		chk(oe, 1'b0, "oe");
		$display("transmit done");
		wr(`PLP_A_TXD, 32'hff);
		clk_bits(2, 32'h0, 1'b0);
		clk_bits(1, 32'h0, 1'b1);
		clk_bits(2, 32'h3, 1'b0);
		chk(oe, 1'b0, "oe");
		rd(`PLP_A_STAT, 32'h86, 32'h84);
		rd(`PLP_A_CTRL, 32'h01, 32'h00);
		send(12'h000);
		wr(`PLP_A_STAT, 32'hf0);
		rd(`PLP_A_STAT, 32'hf4, 32'h00);
		$display("collision done");
		wr(`PLP_A_CTRL, 32'h02);
		en_pin <= 1'b0;
		repeat (8) @(posedge mclk);
		rd(`PLP_A_STAT, 32'h01, 32'h01);
		wr(`PLP_A_CTRL, 32'h00);
		repeat (8) @(posedge mclk);
		rd(`PLP_A_STAT, 32'h01, 32'h00);
		$display("disable done");
		end_sim(0);
	end
endmodule // plp_top_tb
